// ==== ldfm_analog_model.sv ====
// comparator, supply monitor and gate stage model
`timescale 1ns/1ns
`default_nettype none
module ldfm_analog_model
	import ldfm_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic [NUM_FLAGS-1:0] levels,
	input  wire logic                 overStop,
	input  wire logic                 drvEnable,
	output var  logic [NUM_FLAGS-1:0] compFlags,
	output var  logic                 periodEnd,
	output var  logic                 csOverStop,
	output var  logic                 maxOnEnd
);
	logic [2:0] period_q = 3'h0;
	logic [2:0] onTime_q = 3'h0;
	// comparators switch off the clock edge
	always @(levels)
		compFlags <= #3 levels;
	always @(posedge mclk) begin
		period_q <= period_q + 3'h1;
		periodEnd <= period_q == 3'h7;
		csOverStop <= overStop;
		onTime_q <= drvEnable ? onTime_q + 3'h1 : 3'h0;
		maxOnEnd <= onTime_q == 3'h5;
	end
endmodule // ldfm_analog_model
`default_nettype wire

// ==== ldfm_fault_mgr.sv ====
// fault sequencing core with AXI4-Lite status and control
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module ldfm_fault_mgr
	import ldfm_pkg::*;
#(
	parameter int unsigned BO_CYC    = BO_FILT_CYC,
	parameter int unsigned AUX_CYC   = AUX_SHORT_CYC,
	parameter int unsigned REC_CYC   = RECOVER_CYC,
	parameter int unsigned BLANK_CYC = OTP_BLANK_CYC,
	parameter int unsigned GND_CYC   = GND_OPEN_CYC
) (
	input  wire logic                 mclk,
	input  wire logic                 srst,
	input  wire logic                 latchVariant,
	input  wire logic [NUM_FLAGS-1:0] compFlags,
	input  wire logic                 periodEnd,
	input  wire logic                 csOverStop,
	input  wire logic                 maxOnEnd,
	input  wire logic                 drvRequest,
	output var  logic                 drvEnable,
	output var  logic                 startupConsumption,
	output var  logic                 impedanceCheck,
	output var  logic [7:0]           currentScale,
	output var  logic                 irq,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output var  logic                 s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output var  logic                 s_axi_wready,
	output var  logic [1:0]           s_axi_bresp,
	output var  logic                 s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output var  logic                 s_axi_arready,
	output var  logic [31:0]          s_axi_rdata,
	output var  logic [1:0]           s_axi_rresp,
	output var  logic                 s_axi_rvalid,
	input  wire logic                 s_axi_rready
);
	initial begin
		if (BO_CYC < 1 || AUX_CYC < 1 || REC_CYC < 1 || BLANK_CYC < 1 || GND_CYC < 1)
			$error("ldfm_fault_mgr: counts must be at least one");
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// synchronised inputs and static variant

	logic [NUM_FLAGS-1:0] f;
	logic                 variantLatch_q;
	logic                 variantDone_q;
	ldfm_sync #(.W(NUM_FLAGS)) u_sync (
		.mclk (mclk),
		.srst (srst),
		.din  (compFlags),
		.dout (f)
	);
	always_ff @(posedge mclk) begin
		if (srst) begin
			variantLatch_q <= 1'b0;
			variantDone_q  <= 1'b0;
		end else if (!variantDone_q) begin
			variantLatch_q <= latchVariant;
			variantDone_q  <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// qualification timers

	ldfm_state_t state_q;
	logic [31:0] boCnt_q, auxCnt_q, recCnt_q, blankCnt_q, gndCnt_q;
	logic [2:0]  wodCnt_q;
	logic        brownout_q, auxFault_q, wodFault_q, gndFault_q, otpHeld_q, csFault_q;
	logic        tsdHeld_q, csCheck_q, running;
	assign running = (state_q == LDFM_RUN) || (state_q == LDFM_BLANK);

	always_ff @(posedge mclk) begin
		if (srst || !f[F_BOLOW]) begin
			boCnt_q <= '0;
		end else if (boCnt_q < BO_CYC) begin
			boCnt_q <= boCnt_q + 32'd1;
		end
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			brownout_q <= 1'b0;
		end else if (boCnt_q >= BO_CYC) begin
			brownout_q <= 1'b1;
		end else if (f[F_BOHIGH] && f[F_VCCON]) begin
			brownout_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst || !running || f[F_ZCDHI]) begin
			auxCnt_q <= '0;
		end else if (auxCnt_q < AUX_CYC) begin
			auxCnt_q <= auxCnt_q + 32'd1;
		end
	end
	assign auxFault_q = (auxCnt_q >= AUX_CYC);

	always_ff @(posedge mclk) begin
		if (srst || !running) begin
			wodCnt_q <= '0;
		end else if (periodEnd) begin
			if (!csOverStop)
				wodCnt_q <= '0;
			else if (wodCnt_q < 3'(WOD_PERIODS))
				wodCnt_q <= wodCnt_q + 3'd1;
		end
	end
	assign wodFault_q = (wodCnt_q >= 3'(WOD_PERIODS));

	always_ff @(posedge mclk) begin
		if (srst || !f[F_GNDOP]) begin
			gndCnt_q <= '0;
		end else if (gndCnt_q < GND_CYC) begin
			gndCnt_q <= gndCnt_q + 32'd1;
		end
	end
	assign gndFault_q = (gndCnt_q >= GND_CYC);

	always_ff @(posedge mclk) begin
		if (srst) begin
			tsdHeld_q <= 1'b0;
		end else if (f[F_TSD]) begin
			tsdHeld_q <= 1'b1;
		end else begin
			tsdHeld_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// sense-pin impedance check

	always_ff @(posedge mclk) begin
		if (srst) begin
			csCheck_q <= 1'b0;
		end else begin
			csCheck_q <= (state_q == LDFM_BLANK && blankCnt_q == 32'd0) || maxOnEnd;
		end
	end
	assign csFault_q = csCheck_q && f[F_CSLOW];

	////////////////////////////////////////////////////////////////////////////////////////
	// fault classification

	logic otpTrip, latchFault, recoverFault;
	assign otpTrip = (state_q == LDFM_RUN) && f[F_OTP];
	assign latchFault = variantLatch_q
		&& (otpTrip || f[F_SENSE_PIN_OVERVOLTAGE_FAULT] || wodFault_q || auxFault_q);
	assign recoverFault = (!variantLatch_q && (otpTrip || f[F_SENSE_PIN_OVERVOLTAGE_FAULT] || wodFault_q || auxFault_q))
		|| f[F_VCCOVP] || tsdHeld_q || gndFault_q || csFault_q;

	always_ff @(posedge mclk) begin
		if (srst) begin
			otpHeld_q <= 1'b0;
		end else if (otpTrip) begin
			otpHeld_q <= 1'b1;
		end else if (f[F_OTPREL] && !f[F_OTP]) begin
			otpHeld_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// state machine

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q    <= LDFM_OFF;
			blankCnt_q <= '0;
			recCnt_q   <= '0;
		end else begin
			unique case (state_q)
				LDFM_OFF: begin
					if (f[F_VCCON] && !brownout_q && !tsdHeld_q && !otpHeld_q) begin
						state_q    <= LDFM_BLANK;
						blankCnt_q <= '0;
					end
				end
				LDFM_BLANK: begin
					if (latchFault)
						state_q <= LDFM_LATCH;
					else if (recoverFault) begin
						state_q  <= LDFM_RECOVER;
						recCnt_q <= '0;
					end else if (brownout_q)
						state_q <= LDFM_OFF;
					else if (blankCnt_q + 32'd1 >= BLANK_CYC)
						state_q <= LDFM_RUN;
					else
						blankCnt_q <= blankCnt_q + 32'd1;
				end
				LDFM_RUN: begin
					if (latchFault)
						state_q <= LDFM_LATCH;
					else if (recoverFault) begin
						state_q  <= LDFM_RECOVER;
						recCnt_q <= '0;
					end else if (brownout_q)
						state_q <= LDFM_OFF;
				end
				LDFM_RECOVER: begin
					if (recCnt_q + 32'd1 >= REC_CYC)
						state_q <= LDFM_OFF;
					else
						recCnt_q <= recCnt_q + 32'd1;
				end
				LDFM_LATCH: begin
					if (f[F_VCCRST])
						state_q <= LDFM_OFF;
				end
				default: state_q <= LDFM_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// outputs

	always_ff @(posedge mclk) begin
		if (srst) begin
			drvEnable          <= 1'b0;
			startupConsumption <= 1'b1;
			impedanceCheck     <= 1'b0;
			currentScale       <= FOLD_FULL;
		end else begin
			drvEnable          <= drvRequest && state_q == LDFM_RUN && !latchFault
				&& !recoverFault && !brownout_q;
			startupConsumption <= (state_q == LDFM_OFF);
			impedanceCheck     <= csCheck_q;
			if (f[F_TFEND])
				currentScale <= FOLD_HALF;
			else if (f[F_TFBEG])
				currentScale <= FOLD_MID;
			else
				currentScale <= FOLD_FULL;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// interrupt status and mask

	logic [NUM_EV-1:0] events, status_q, mask_q, w1c;
	logic [31:0]       wdataHold_q;
	logic [7:0]        awaddrHold_q;
	logic              awHave_q, wHave_q, doWrite;
	assign events = {brownout_q, gndFault_q, csFault_q, tsdHeld_q, f[F_VCCOVP],
		auxFault_q, wodFault_q, f[F_SENSE_PIN_OVERVOLTAGE_FAULT], otpTrip};
	assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
	assign w1c = (doWrite && awaddrHold_q == A_STATUS && wdataHold_q != 32'h0
		&& s_axi_wstrb != 4'h0) ? wdataHold_q[NUM_EV-1:0] : '0;

	always_ff @(posedge mclk) begin
		if (srst) begin
			status_q <= '0;
			mask_q   <= MASK_RST;
			irq      <= 1'b0;
		end else begin
			status_q <= (status_q & ~w1c) | events;
			if (doWrite && awaddrHold_q == A_MASK)
				mask_q <= wdataHold_q[NUM_EV-1:0];
			irq <= |(status_q & mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	always_ff @(posedge mclk) begin
		if (srst) begin
			awHave_q      <= 1'b0;
			wHave_q       <= 1'b0;
			awaddrHold_q  <= '0;
			wdataHold_q   <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !awHave_q && !s_axi_awready;
			s_axi_wready  <= !wHave_q && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_q     <= 1'b1;
				awaddrHold_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_q     <= 1'b1;
				wdataHold_q <= s_axi_wdata;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddrHold_q == A_STATUS || awaddrHold_q == A_MASK)
					? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHave_q     <= 1'b0;
				wHave_q      <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				unique case (s_axi_araddr)
					A_STATUS: s_axi_rdata <= 32'(status_q);
					A_MASK:   s_axi_rdata <= 32'(mask_q);
					A_FAULT:  s_axi_rdata <= 32'({tsdHeld_q, otpHeld_q, state_q});
					A_CTRL:   s_axi_rdata <= 32'({currentScale, variantLatch_q});
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // ldfm_fault_mgr
`default_nettype wire

// ==== ldfm_fault_mgr_bench.sv ====
// self-checking bench for the fault manager
`timescale 1ns/1ns
`default_nettype none
module ldfm_fault_mgr_bench import ldfm_pkg::*;;
	localparam logic [13:0] BASE = 14'h2221;
	localparam int REC = 200;
	localparam logic [13:0] FX [7] = '{14'h0030, 14'h0040, 14'h0080, 14'h0400,
		14'h1000, 14'h0300, 14'h2000};
	localparam int EV [7] = '{E_OTP, E_SENSE_PIN_OVERVOLTAGE_FAULT, E_VCCOV, E_TSD, E_GNDOP, E_BO, E_AUX};
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        latchVariant = 1'b0;
	logic [13:0] levels = 14'h0;
	logic        overStop = 1'b0;
	logic        drvRequest = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h0;
	logic [7:0]  s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [13:0] compFlags;
	logic [7:0]  currentScale;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        periodEnd, csOverStop, maxOnEnd, drvEnable, startupConsumption, irq;
	logic        impedanceCheck, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	integer      seed = 13;
	int          rnd, errors = 0, checks = 0, cyc = 0, tn = 0;
	logic [33:0] expQ [$];
	always #5 mclk = ~mclk;
	ldfm_fault_mgr #(.BO_CYC(60), .AUX_CYC(60), .REC_CYC(REC), .BLANK_CYC(40), .GND_CYC(40)) dut (
		.mclk, .srst, .latchVariant, .compFlags, .periodEnd, .csOverStop, .maxOnEnd,
		.drvRequest, .drvEnable, .startupConsumption, .impedanceCheck, .currentScale, .irq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	ldfm_analog_model ana (.mclk, .levels, .overStop, .drvEnable, .compFlags, .periodEnd,
		.csOverStop, .maxOnEnd);
	////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic done;
		tn = tn + 1;
		$display("test %0d done", tn);
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		expQ.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w) begin
			@(posedge mclk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do
			@(posedge mclk);
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic axr(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
		expQ.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge mclk);
		while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge mclk);
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rst(input logic v);
		srst <= 1'b1;
		latchVariant <= v;
		levels <= BASE;
		wt(12);
		srst <= 1'b0;
		wt(80);
	endtask
	task automatic fault(input logic [13:0] x, input int ev, input logic m);
		axw(A_MASK, {31'h0, m} << ev, RESP_OKAY);
		levels <= BASE ^ x;
		wt(100);
		axr(A_STATUS, RESP_OKAY, 32'h1 << ev);
		cmp({32'h0, irq, drvEnable}, {32'h0, m, 1'b0});
		levels <= BASE;
		wt(4);
		axw(A_STATUS, 32'h1 << ev, RESP_OKAY);
		wt(REC * 2);
		axr(A_STATUS, RESP_OKAY, 32'h0);
		axr(A_FAULT, RESP_OKAY, 32'h2);
		cmp({33'h0, irq}, 34'h0);
		done;
	endtask
	////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		rnd = $random(seed);
		drvRequest <= rnd[1:0] != 2'b00;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			give_verdict();
		end
	end
	always @(posedge mclk) begin
		if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))
			cmp(s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}, expQ.pop_front());
	end
	initial begin
		rst(1'b0);
		axr(A_FAULT, RESP_OKAY, 32'h2);
		axr(A_MASK, RESP_OKAY, 32'h0);
		axr(8'h10, RESP_SLVERR, 32'h0);
		axw(A_FAULT, 32'hFF, RESP_SLVERR);
		levels <= BASE | 14'h0004;
		wt(10);
		axr(A_CTRL, RESP_OKAY, 32'h180);
		levels <= BASE | 14'h000C;
		wt(10);
		axr(A_CTRL, RESP_OKAY, 32'h100);
		levels <= BASE;
		wt(10);
		axr(A_CTRL, RESP_OKAY, 32'h1FE);
		done;
		for (int i = 0; i < 7; i++)
			fault(FX[i], EV[i], i[0]);
		rst(1'b1);
		axr(A_CTRL, RESP_OKAY, 32'h1FF);
		overStop <= 1'b1;
		wt(40);
		overStop <= 1'b0;
		axr(A_STATUS, RESP_OKAY, 32'h1 << E_WOD);
		axr(A_FAULT, RESP_OKAY, 32'h4);
		wt(REC * 2);
		axr(A_FAULT, RESP_OKAY, 32'h4);
		levels <= 14'h0002;
		wt(20);
		axr(A_FAULT, RESP_OKAY, 32'h0);
		cmp({33'h0, startupConsumption}, 34'h1);
		levels <= BASE;
		wt(80);
		axr(A_FAULT, RESP_OKAY, 32'h2);
		levels <= BASE ^ 14'h0080;
		wt(20);
		axr(A_FAULT, RESP_OKAY, 32'h3);
		levels <= BASE;
		wt(REC * 2);
		levels <= BASE | 14'h0800;
		wt(100);
		axr(A_FAULT, RESP_OKAY, 32'h3);
		levels <= BASE;
		wt(REC * 2);
		levels <= BASE ^ 14'h0030;
		wt(20);
		levels <= BASE;
		wt(REC * 2);
		cmp({33'h0, drvEnable}, 34'h0);
		done;
		give_verdict();
	end
endmodule // ldfm_fault_mgr_bench
`default_nettype wire

// ==== ldfm_fault_mgr_properties.sv ====
// port assertions for the fault manager
`timescale 1ns/1ns
`default_nettype none
module ldfm_fault_mgr_chk
	import ldfm_pkg::*;
#(
	parameter int unsigned BLANK_CYC = OTP_BLANK_CYC
) (
	input wire logic                 mclk,
	input wire logic                 srst,
	input wire logic [NUM_FLAGS-1:0] compFlags,
	input wire logic                 drvRequest,
	input wire logic                 maxOnEnd,
	input wire logic                 drvEnable,
	input wire logic                 startupConsumption,
	input wire logic                 impedanceCheck,
	input wire logic [7:0]           currentScale
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// cycles since the block left the idle state
	logic [15:0] onCnt_q;
	always_ff @(posedge mclk) begin
		if (srst || startupConsumption)
			onCnt_q <= 16'h0;
		else if (onCnt_q != 16'hFFFF)
			onCnt_q <= onCnt_q + 16'h1;
	end
	////////////////////////////////////////////////////////////
	a_reset_values: assert property ($fell(srst) |-> !drvEnable && startupConsumption)
		else $error("outputs not at reset values");
	a_drive_request: assert property (drvEnable |-> $past(drvRequest))
		else $error("drive without request");
	a_supply_ovp_stop: assert property (compFlags[F_VCCOVP] [*6] |-> !drvEnable)
		else $error("drive during supply overvoltage");
	a_die_hot_stop: assert property (compFlags[F_TSD] [*6] |-> !drvEnable)
		else $error("drive during die overheat");
	a_fold_half: assert property (compFlags[F_TFEND] [*6] |-> currentScale == FOLD_HALF)
		else $error("scale not half at foldback end");
	a_run_not_idle: assert property (drvEnable |-> !startupConsumption)
		else $error("drive while idle");
	a_blank_first: assert property (drvEnable |-> onCnt_q >= BLANK_CYC)
		else $error("drive inside blanking");
	a_maxon_check: assert property (maxOnEnd && !startupConsumption |-> ##[1:4] impedanceCheck)
		else $error("no impedance check after max on");
endmodule // ldfm_fault_mgr_chk
bind ldfm_fault_mgr ldfm_fault_mgr_chk #(.BLANK_CYC(BLANK_CYC)) chk (.mclk, .srst, .compFlags,
	.drvRequest, .maxOnEnd, .drvEnable, .startupConsumption, .impedanceCheck, .currentScale);
`default_nettype wire

// ==== ldfm_pkg.sv ====
// constants and register map of the led driver fault manager
package ldfm_pkg;
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned OTP_BLANK_US  = 250;
	localparam int unsigned BO_FILT_MS    = 25;
	localparam int unsigned GND_OPEN_US   = 200;
	localparam int unsigned AUX_SHORT_MS  = 90;
	localparam int unsigned RECOVER_S     = 4;
	localparam int unsigned OTP_BLANK_CYC = OTP_BLANK_US * (CLK_HZ / 1_000_000);
	localparam int unsigned GND_OPEN_CYC  = GND_OPEN_US * (CLK_HZ / 1_000_000);
	localparam int unsigned BO_FILT_CYC   = BO_FILT_MS * (CLK_HZ / 1_000);
	localparam int unsigned AUX_SHORT_CYC = AUX_SHORT_MS * (CLK_HZ / 1_000);
	localparam int unsigned RECOVER_CYC   = RECOVER_S * CLK_HZ;
	localparam int unsigned WOD_PERIODS   = 4;
	localparam int unsigned NUM_FLAGS     = 14;
	// synchronised flag indices
	localparam int unsigned F_VCCON  = 0;
	localparam int unsigned F_VCCRST = 1;
	localparam int unsigned F_TFBEG  = 2;
	localparam int unsigned F_TFEND  = 3;
	localparam int unsigned F_OTP    = 4;
	localparam int unsigned F_OTPREL = 5;
	localparam int unsigned F_SENSE_PIN_OVERVOLTAGE_FAULT   = 6;
	localparam int unsigned F_VCCOVP = 7;
	localparam int unsigned F_BOLOW  = 8;
	localparam int unsigned F_BOHIGH = 9;
	localparam int unsigned F_TSD    = 10;
	localparam int unsigned F_CSLOW  = 11;
	localparam int unsigned F_GNDOP  = 12;
	localparam int unsigned F_ZCDHI  = 13;
	// AXI4-Lite register byte addresses
	localparam logic [7:0] A_STATUS = 8'h00;
	localparam logic [7:0] A_MASK   = 8'h04;
	localparam logic [7:0] A_FAULT  = 8'h08;
	localparam logic [7:0] A_CTRL   = 8'h0C;
	// event bit positions in status and mask
	localparam int unsigned NUM_EV  = 9;
	localparam int unsigned E_OTP   = 0;
	localparam int unsigned E_SENSE_PIN_OVERVOLTAGE_FAULT  = 1;
	localparam int unsigned E_WOD   = 2;
	localparam int unsigned E_AUX   = 3;
	localparam int unsigned E_VCCOV = 4;
	localparam int unsigned E_TSD   = 5;
	localparam int unsigned E_CSSH  = 6;
	localparam int unsigned E_GNDOP = 7;
	localparam int unsigned E_BO    = 8;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [8:0] MASK_RST    = 9'h000;
	localparam logic [7:0] FOLD_FULL   = 8'hFF;
	localparam logic [7:0] FOLD_HALF   = 8'h80;
	localparam logic [7:0] FOLD_MID    = 8'hC0;
	typedef enum logic [2:0] {LDFM_OFF, LDFM_BLANK, LDFM_RUN, LDFM_RECOVER, LDFM_LATCH}
		ldfm_state_t;
endpackage

// ==== ldfm_sync.sv ====
// two-flop synchroniser bank
`timescale 1ns/1ns
`default_nettype none
module ldfm_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         mclk,
	input  wire logic         srst,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] meta_q;
	always_ff @(posedge mclk) begin
		if (srst) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule // ldfm_sync
`default_nettype wire
